// File: logic/hsc_pkg.sv
// Package for the high-speed serdes control register bank
// Assumes a classic Wishbone slave with 32-bit data and byte addresses
//
// Contract
// (R01) Swing field 15:12 of swing/rate register, reset 1000
// (R02) Swing codes map to rising amplitudes 130..1400 mV
// (R03) Tx enable bit 11; forced off by pin/global
// (R04) Rx enable bit 3; forced off by pin/global
// (R05) Bit 10 holds equalizer and tail correction
// (R06) Tx rate 9:8 decodes full/half/quarter/eighth
// (R07) Rx rate 2:0 decodes; other codes reserved
// (R08) Rate fields automatic unless alt-ref or override
// (R09) Eq/cdr register at index 0x0004, reset 0x1400
// (R10) Bit 15 forces receive ADC into track
// (R11) Precursor eq 14:12 amplitudes; 111 disables
// (R12) Recovery order 11:10; 11 reserved; reset 01
// (R13) Vote threshold 9:8 gives 4/8/16/32
// (R14) Bit 6 disables high-frequency peaking
// (R15) Bit 5 selects short channel recovery mode
// (R16) Cursor reduction code bits 4:0, reset zero
// (R17) Cursor codes 00111..01111 are reserved
// (R18) Software writes reserved fields with reset values
package hsc_pkg;
   // ---------------------------------------------------------------
   // Register map (index; byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [3:0]  HSC_IDX_SWING_RATE = 4'h3;
   localparam logic [3:0]  HSC_IDX_EQ_CDR     = 4'h4;
   localparam logic [3:0]  HSC_IDX_STATUS     = 4'h8;
   localparam logic [15:0] HSC_RST_SWING_RATE = 16'h8848;
   localparam logic [15:0] HSC_RST_EQ_CDR     = 16'h1400;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int HSC_SWING_LSB   = 12;
   localparam int HSC_TXEN_BIT    = 11;
   localparam int HSC_EQHOLD_BIT  = 10;
   localparam int HSC_TXRATE_LSB  = 8;
   localparam int HSC_RXEN_BIT    = 3;
   localparam int HSC_RXRATE_LSB  = 0;
   localparam int HSC_TRACK_BIT   = 15;
   localparam int HSC_PRE_LSB     = 12;
   localparam int HSC_ORDER_LSB   = 10;
   localparam int HSC_VOTE_LSB    = 8;
   localparam int HSC_PEAK_BIT    = 6;
   localparam int HSC_SHORT_BIT   = 5;
   localparam int HSC_CRF_LSB     = 0;

   typedef enum logic [1:0] {HSC_TX_FULL, HSC_TX_HALF, HSC_TX_QUARTER, HSC_TX_EIGHTH} hsc_tx_rate_t;

   // Decoded analogue controls towards the serdes macro
   typedef struct packed {
      logic [3:0]  tx_output_swing;
      logic [10:0] swing_mv;
      logic        tx_on;
      logic        rx_on;
      logic        rx_equalizer_hold;
      logic [1:0]  tx_rate_select;
      logic [2:0]  rx_rate_select;
      logic        rx_rate_reserved;
      logic        adc_track_force;
      logic [2:0]  rx_precursor_eq;
      logic        precursor_off;
      logic [1:0]  recovery_loop_order;
      logic        order_reserved;
      logic [5:0]  recovery_votes;
      logic        hf_peaking_off;
      logic        short_channel_recovery_mode;
      logic [4:0]  cursor_reduction_code;
      logic        crf_reserved;
   } hsc_ctrl_t;
endpackage

// File: logic/hsc_regs.sv
// Serdes control register bank with decoded control outputs
// Assumes synchronous Wishbone master and asynchronous pins for power-down and ref select
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module hsc_regs (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   input  wire logic             we_i,
   input  wire logic [5:0]       adr_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic [31:0]      dat_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   // Pins and device-level controls
   input  wire logic             channel_power_down_n_i,
   input  wire logic             global_power_down_i,
   input  wire logic             alt_reference_frequency_select_i,
   input  wire logic             rate_override_i,
   input  wire logic [1:0]       auto_tx_rate_i,
   input  wire logic [2:0]       auto_rx_rate_i,
   // Decoded controls
   output hsc_pkg::hsc_ctrl_t    ctrl_o
);
   import hsc_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   // Two stages before any logic reads the pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= 3'h1;
         pin_sync <= 3'h1;
      end else begin
         pin_meta <= {rate_override_i, alt_reference_frequency_select_i, channel_power_down_n_i};
         pin_sync <= pin_meta;
      end
   end
   wire pd_n_s     = pin_sync[0];
   wire alt_ref_s  = pin_sync[1];
   wire override_s = pin_sync[2];

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic [15:0] swing_rate;
   logic [15:0] eq_cdr;
   wire         req      = cyc_i & stb_i & ~ack_o;
   wire  [3:0]  idx      = adr_i[5:2];
   wire         hit_sr   = idx == HSC_IDX_SWING_RATE;
   wire         hit_eq   = idx == HSC_IDX_EQ_CDR;
   wire         hit_st   = idx == HSC_IDX_STATUS;
   wire         wr_sr    = req & we_i & hit_sr;
   wire         wr_eq    = req & we_i & hit_eq;
   // Only the low two byte lanes carry register bits
   wire  [15:0] lane_msk = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   wire  [15:0] next_sr  = (swing_rate & ~lane_msk) | (dat_i[15:0] & lane_msk);
   wire  [15:0] next_eq  = (eq_cdr & ~lane_msk) | (dat_i[15:0] & lane_msk);

   // Status shows the effective state that logic actually uses
   wire  [15:0] status   = {8'h00, ctrl_o.crf_reserved, ctrl_o.order_reserved, ctrl_o.rx_rate_reserved,
                            ctrl_o.tx_on, ctrl_o.rx_on, alt_ref_s, override_s, pd_n_s};
   wire  [15:0] rd_mux   = hit_sr ? swing_rate : hit_eq ? eq_cdr : hit_st ? status : 16'h0000;

   // ---------------------------------------------------------------
   // Register storage and single-cycle ack
   // ---------------------------------------------------------------
   // Ack one cycle after the request; unmapped addresses ack with zero data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         dat_o <= req ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   // Reserved bits are stored as written; software keeps them at reset values [R18]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         swing_rate <= HSC_RST_SWING_RATE;  // [R01]
         eq_cdr     <= HSC_RST_EQ_CDR;      // [R09]
      end else begin
         if (wr_sr) begin
            swing_rate <= next_sr;
         end
         if (wr_eq) begin
            eq_cdr <= next_eq;
         end
      end
   end

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   wire       pwr_ok   = pd_n_s & ~global_power_down_i;
   wire       sw_rate  = alt_ref_s | override_s;
   wire [3:0] swing    = swing_rate[HSC_SWING_LSB +: 4];
   wire [1:0] tx_rate  = sw_rate ? swing_rate[HSC_TXRATE_LSB +: 2] : auto_tx_rate_i;  // [R08]
   wire [2:0] rx_rate  = sw_rate ? swing_rate[HSC_RXRATE_LSB +: 3] : auto_rx_rate_i;  // [R08]
   wire [2:0] pre      = eq_cdr[HSC_PRE_LSB +: 3];
   wire [1:0] order    = eq_cdr[HSC_ORDER_LSB +: 2];
   wire [1:0] vote     = eq_cdr[HSC_VOTE_LSB +: 2];
   wire [4:0] crf      = eq_cdr[HSC_CRF_LSB +: 5];
   // Rx codes 001, 01x and 100 are reserved
   wire       rx_res   = (rx_rate != 3'h0) & (rx_rate[2:1] != 2'h3) & (rx_rate != 3'h5);  // [R07]
   wire [5:0] votes    = 6'h04 << vote;                                   // [R13]
   wire       crf_res  = (crf[4] == 1'b0) & (crf[3:0] > 4'h6);            // [R17]

   // Typical amplitude per swing code, monotonic in the code
   logic [10:0] swing_mv;
   always_comb begin
      unique case (swing)                                                 // [R02]
         4'h0: swing_mv = 11'd130;
         4'h1: swing_mv = 11'd220;
         4'h2: swing_mv = 11'd300;
         4'h3: swing_mv = 11'd390;
         4'h4: swing_mv = 11'd480;
         4'h5: swing_mv = 11'd570;
         4'h6: swing_mv = 11'd660;
         4'h7: swing_mv = 11'd750;
         4'h8: swing_mv = 11'd830;
         4'h9: swing_mv = 11'd930;
         4'ha: swing_mv = 11'd1020;
         4'hb: swing_mv = 11'd1110;
         4'hc: swing_mv = 11'd1180;
         4'hd: swing_mv = 11'd1270;
         4'he: swing_mv = 11'd1340;
         4'hf: swing_mv = 11'd1400;
      endcase
   end

   // ---------------------------------------------------------------
   // Registered control outputs
   // ---------------------------------------------------------------
   hsc_ctrl_t next_ctrl;
   always_comb begin
      next_ctrl.tx_output_swing             = swing;                                    // [R01]
      next_ctrl.swing_mv                    = swing_mv;
      next_ctrl.tx_on                       = swing_rate[HSC_TXEN_BIT] & pwr_ok;         // [R03]
      next_ctrl.rx_on                       = swing_rate[HSC_RXEN_BIT] & pwr_ok;         // [R04]
      next_ctrl.rx_equalizer_hold           = swing_rate[HSC_EQHOLD_BIT];                // [R05]
      next_ctrl.tx_rate_select              = tx_rate;                                   // [R06]
      next_ctrl.rx_rate_select              = rx_rate;                                   // [R07]
      next_ctrl.rx_rate_reserved            = rx_res;
      next_ctrl.adc_track_force             = eq_cdr[HSC_TRACK_BIT];                     // [R10]
      next_ctrl.rx_precursor_eq             = pre;                                       // [R11]
      next_ctrl.precursor_off               = pre == 3'h7;                               // [R11]
      next_ctrl.recovery_loop_order         = order;                                     // [R12]
      next_ctrl.order_reserved              = order == 2'h3;                             // [R12]
      next_ctrl.recovery_votes              = votes;
      next_ctrl.hf_peaking_off              = eq_cdr[HSC_PEAK_BIT];                      // [R14]
      next_ctrl.short_channel_recovery_mode = eq_cdr[HSC_SHORT_BIT];                     // [R15]
      next_ctrl.cursor_reduction_code       = crf;                                       // [R16]
      next_ctrl.crf_reserved                = crf_res;
   end

   // One register stage keeps every top output flop-driven
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_o <= '0;
      end else begin
         ctrl_o <= next_ctrl;
      end
   end
endmodule

// File: tb/hsc_regs_chk.sv
// Checker for the serdes control register bank, bound to its top module
// Assumes hsc_pkg is compiled first and that only top-level ports are visible
`timescale 1ns/1ps
module hsc_regs_chk (
   // Clock, reset and bus
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic               cyc_i,
   input wire logic               stb_i,
   input wire logic [31:0]        dat_o,
   input wire logic               ack_o,
   // Pins and decoded controls
   input wire logic               channel_power_down_n_i,
   input wire logic               global_power_down_i,
   input wire logic               alt_reference_frequency_select_i,
   input wire logic               rate_override_i,
   input wire logic [1:0]         auto_tx_rate_i,
   input wire logic [2:0]         auto_rx_rate_i,
   input wire hsc_pkg::hsc_ctrl_t ctrl_o
);
   import hsc_pkg::*;
   // -------------------------------------------------
   // Bus handshake and decoded controls
   // -------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_ack_take; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_take: assert property (p_ack_take) else $error("no ack");
   property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data off ack");
   property p_dat_hi; ack_o |-> dat_o[31:16] == 16'h0; endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper bits set");
   // Pins pass two sync flops, so a few cycles of margin are given
   property p_pd_off; !channel_power_down_n_i [*5] |-> !ctrl_o.tx_on && !ctrl_o.rx_on; endproperty
   a_pd_off: assert property (p_pd_off) else $error("on in power down");
   property p_gpd_off; global_power_down_i [*3] |-> !ctrl_o.tx_on && !ctrl_o.rx_on; endproperty
   a_gpd_off: assert property (p_gpd_off) else $error("on in global down");
   property p_auto_rate;
      (!alt_reference_frequency_select_i && !rate_override_i && $stable(auto_tx_rate_i)
         && $stable(auto_rx_rate_i)) [*6]
      |-> ctrl_o.tx_rate_select == auto_tx_rate_i && ctrl_o.rx_rate_select == auto_rx_rate_i;
   endproperty
   a_auto_rate: assert property (p_auto_rate) else $error("rate not automatic");
   property p_pre_off; ctrl_o.precursor_off == (ctrl_o.rx_precursor_eq == 3'h7); endproperty
   a_pre_off: assert property (p_pre_off) else $error("precursor off wrong");
   property p_ord_res; ctrl_o.order_reserved == (ctrl_o.recovery_loop_order == 2'h3); endproperty
   a_ord_res: assert property (p_ord_res) else $error("order flag wrong");
   property p_crf_res; ctrl_o.crf_reserved == (ctrl_o.cursor_reduction_code inside {[5'h07:5'h0f]}); endproperty
   a_crf_res: assert property (p_crf_res) else $error("cursor flag wrong");
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the serdes control register bank
// Assumes hsc_pkg, hsc_regs and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
   import hsc_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic        pd_n = 1'b1, gpd = 1'b0, alt = 1'b0, ovr = 1'b0;
   logic [5:0]  adr_i = 6'h0;
   logic [3:0]  sel_i = 4'h3;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [1:0]  atx = 2'h2;
   logic [2:0]  arx = 3'h6;
   hsc_ctrl_t   ctrl_o;
   int          miscompares = 0, checks = 0, cycles = 0;
   hsc_regs u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .channel_power_down_n_i(pd_n), .global_power_down_i(gpd), .alt_reference_frequency_select_i(alt),
      .rate_override_i(ovr), .auto_tx_rate_i(atx), .auto_rx_rate_i(arx), .ctrl_o);
   // -------------------------------------------------
   // Clock, timeout and shared tasks
   // -------------------------------------------------
   always #12.5 clk_i = ~clk_i;
   // Whole run is about 130 cycles; the ceiling leaves ample slack
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      if (miscompares == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; request held until ack is seen, then released
   task automatic wb(input logic w, input logic [3:0] idx, input logic [15:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {16'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // -------------------------------------------------
   // Scenarios
   // -------------------------------------------------
   task automatic t_defaults;
      wb(1'b0, HSC_IDX_SWING_RATE, 16'h0);
      chk(rd, 32'h8848);
      wb(1'b0, HSC_IDX_EQ_CDR, 16'h0);
      chk(rd, 32'h1400);
      chk(ctrl_o.swing_mv, 32'd830);
      chk({ctrl_o.tx_on, ctrl_o.rx_on, ctrl_o.rx_equalizer_hold, ctrl_o.rx_precursor_eq}, 32'h31);
      chk(ctrl_o.recovery_votes, 32'h4);
   endtask
   task automatic t_swing;
      wb(1'b1, HSC_IDX_SWING_RATE, 16'h0c48);
      wb(1'b0, HSC_IDX_SWING_RATE, 16'h0);
      chk({ctrl_o.tx_output_swing, ctrl_o.swing_mv, ctrl_o.rx_equalizer_hold}, {4'h0, 11'd130, 1'b1});
      wb(1'b1, HSC_IDX_SWING_RATE, 16'hf848);
      wb(1'b0, HSC_IDX_SWING_RATE, 16'h0);
      chk(rd, 32'hf848);
      chk({ctrl_o.tx_output_swing, ctrl_o.swing_mv, ctrl_o.rx_equalizer_hold}, {4'hf, 11'd1400, 1'b0});
   endtask
   task automatic t_eq;
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, HSC_IDX_EQ_CDR, {1'b1, 3'h7, 2'h1, c[1:0], 3'h3, 5'h1f});
         wb(1'b0, HSC_IDX_EQ_CDR, 16'h0);
         chk(rd, {16'h0, 1'b1, 3'h7, 2'h1, c[1:0], 3'h3, 5'h1f});
         chk(ctrl_o.recovery_votes, 32'h4 << c);
         chk({ctrl_o.adc_track_force, ctrl_o.precursor_off, ctrl_o.recovery_loop_order, ctrl_o.hf_peaking_off,
            ctrl_o.short_channel_recovery_mode, ctrl_o.cursor_reduction_code}, 32'h6ff);
      end
      wb(1'b1, HSC_IDX_EQ_CDR, 16'h1c08);
      wb(1'b0, HSC_IDX_EQ_CDR, 16'h0);
      chk({ctrl_o.order_reserved, ctrl_o.crf_reserved}, 32'h3);
      // Upper lane only: the low byte must keep its stored value
      sel_i <= 4'h2;
      wb(1'b1, HSC_IDX_EQ_CDR, 16'h2c55);
      sel_i <= 4'h3;
      wb(1'b0, HSC_IDX_EQ_CDR, 16'h0);
      chk(rd, 32'h2c08);
   endtask
   task automatic t_rates;
      logic [2:0] rx_tab [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
      ovr <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, HSC_IDX_SWING_RATE, {6'h22, i[1:0], 5'h09, rx_tab[i]});
         wb(1'b0, HSC_IDX_EQ_CDR, 16'h0);
         chk({ctrl_o.tx_rate_select, ctrl_o.rx_rate_select, ctrl_o.rx_rate_reserved}, {i[1:0], rx_tab[i], 1'b0});
      end
      // Reserved receive code 001 must raise the reserved flag
      wb(1'b1, HSC_IDX_SWING_RATE, 16'h8b49);
      wb(1'b0, HSC_IDX_EQ_CDR, 16'h0);
      chk({ctrl_o.tx_rate_select, ctrl_o.rx_rate_select, ctrl_o.rx_rate_reserved}, 32'h33);
      ovr <= 1'b0;
      alt <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk({ctrl_o.tx_rate_select, ctrl_o.rx_rate_select}, 32'h19);
      alt <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk({ctrl_o.tx_rate_select, ctrl_o.rx_rate_select}, {atx, arx});
   endtask
   task automatic t_power;
      wb(1'b1, HSC_IDX_SWING_RATE, 16'h8840);
      wb(1'b0, 4'h5, 16'h0);
      chk({rd[15:0], ctrl_o.tx_on, ctrl_o.rx_on}, 32'h2);
      wb(1'b1, HSC_IDX_SWING_RATE, 16'h8848);
      pd_n <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk({ctrl_o.tx_on, ctrl_o.rx_on}, 32'h0);
      pd_n <= 1'b1;
      gpd <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk({ctrl_o.tx_on, ctrl_o.rx_on}, 32'h0);
      gpd <= 1'b0;
      wb(1'b1, 4'h5, 16'hffff);
      wb(1'b0, HSC_IDX_SWING_RATE, 16'h0);
      chk({rd[15:0], ctrl_o.tx_on, ctrl_o.rx_on}, 32'h22123);
      // Status is read only; a write there must change nothing
      wb(1'b1, HSC_IDX_STATUS, 16'hffff);
      wb(1'b0, HSC_IDX_STATUS, 16'h0);
      chk(rd, 32'hd9);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_defaults();
      t_swing();
      t_eq();
      t_rates();
      t_power();
      wrap_up();
   end
endmodule
bind hsc_regs hsc_regs_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .channel_power_down_n_i,
   .global_power_down_i, .alt_reference_frequency_select_i, .rate_override_i, .auto_tx_rate_i,
   .auto_rx_rate_i, .ctrl_o);
